// ==== hdl/t1rx_stat_map.svh ====
// constants for the receive framer status register group of one port
// assumes: included by bare name from the design file and the bench
`ifndef T1RX_STAT_MAP_SVH
`define T1RX_STAT_MAP_SVH

// ----------------------------------------------------------------
// register indexes within a port (byte address is four times this)
// ----------------------------------------------------------------
`define T1RX_IDX_FEA_HIGH 14'h0058
`define T1RX_IDX_FEA_LOW 14'h0059
`define T1RX_IDX_FEB_HIGH 14'h005a
`define T1RX_IDX_FEB_LOW 14'h005b
`define T1RX_IDX_CTRL_ONE 14'h005f
`define T1RX_IDX_TS_MON 14'h0060
`define T1RX_IDX_MON_SEL 14'h0061
`define T1RX_IDX_LINK 14'h0062
`define T1RX_IDX_BOC 14'h0063
`define T1RX_IDX_CAP_ONE 14'h0064
`define T1RX_IDX_CAP_TWO 14'h0065
`define T1RX_IDX_CAP_THREE 14'h0066
`define T1RX_IDX_ODD_SI 14'h0067

// ----------------------------------------------------------------
// per-port placement
// ----------------------------------------------------------------
`define T1RX_PORT_STRIDE 14'h0200
`define T1RX_BANK_STRIDE 14'h2000

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define T1RX_CRC4_EN_BIT 3
`define T1RX_CSC_MAX 6'h3f
`define T1RX_FEC_MAX 16'hffff
`define T1RX_RST_BYTE 8'h00
`define T1RX_RST_WORD 16'h0000

`endif

// ==== hdl/t1rx_stat_pkg.sv ====
// types for the receive framer status register group
// assumes: compiled before the design file
package t1rx_stat_pkg;

  // ----------------------------------------------------------------
  // bus slave handshake states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    T1RX_BUS_IDLE = 2'b01,
    T1RX_BUS_ACK = 2'b10
  } t1rx_bus_state_type;

endpackage : t1rx_stat_pkg

// ==== hdl/t1rx_stat_regs.sv ====
// receive framer status register group for one port, Avalon-MM slave
// assumes: all line-side inputs come from framer logic on mclk (no sync);
// event inputs are one-cycle pulses; the port number is fixed per instance
//
// Notes on behaviour
// [R01] far-end A count, 16 bits, high then low
// [R02] far-end B count, 16 bits, high then low
// [R03] selected timeslot byte, first bit in bit7
// [R04] T1 data link byte, earliest bit lsb
// [R05] D4: update at multiframe, six Fs bits low
// [R06] E1: link offset shows live sync status
// [R07] sync counter counts each failed search period
// [R08] sync counter clears on CRC-4 sync
// [R09] sync counter clears when CRC-4 disabled
// [R10] 6-bit saturating counter, bits 5..2,0 shown
// [R11] controller abandons search after limit
// [R12] live search flags in bits 2..0
// [R13] T1 keeps last valid six-bit code
// [R14] T1: three SLC-96 link capture registers
// [R15] line mode selects T1 or E1 meaning
// [R16] E1 align frame byte capture
// [R17] E1 non-align frame byte capture
// [R18] even-frame international bits into one byte
// [R19] odd-frame international bits into one byte
// [R20] port group placed by port index formula
// [R21] status registers read-only, zero after reset
`timescale 1ns/1ps
`default_nettype none
`include "t1rx_stat_map.svh"

module t1rx_stat_regs #(
  parameter logic [3:0] PORT_INDEX = 4'h0 // zero-based port number
) (
  input wire logic mclk,
  input wire logic reset_n,
  // avalon-mm slave, byte address
  input wire logic [15:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // line mode and framing
  input wire logic line_mode_e1,
  input wire logic d4_framing,
  // far-end error events
  input wire logic far_end_a_event,
  input wire logic far_end_b_event,
  // receive payload bit stream
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic [4:0] rx_timeslot,
  input wire logic [2:0] rx_bit_pos,
  // T1 data link and Fs bits
  input wire logic data_link_valid,
  input wire logic data_link_bits,
  input wire logic fs_bit_valid,
  input wire logic fs_bit,
  input wire logic multiframe_start,
  input wire logic boc_valid,
  input wire logic [5:0] boc_bits,
  // SLC-96 link fields, captured on slc_valid
  input wire logic slc_valid,
  input wire logic [10:0] slc_c_bits,
  input wire logic [2:0] slc_m_bits,
  input wire logic [1:0] slc_a_bits,
  input wire logic [3:0] slc_s_bits,
  // E1 timeslot zero and sync search
  input wire logic ts0_valid,
  input wire logic [7:0] ts0_byte,
  input wire logic [3:0] ts0_frame,
  input wire logic crc4_search_timeout,
  input wire logic crc4_sync_found,
  input wire logic crc4_search_active,
  input wire logic cas_search_active,
  input wire logic fas_search_active,
  // control bits for the framer around us
  output logic crc4_enable
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [13:0] port_base; // index of this port's group
  logic [13:0] reg_index; // index of the addressed register
  logic in_port; // aligned and inside this port

  // [R20] port placement
  assign port_base = 14'(`T1RX_PORT_STRIDE * 14'(PORT_INDEX))
    + 14'(`T1RX_BANK_STRIDE * 14'(PORT_INDEX[3]));
  assign reg_index = address[15:2] - port_base;
  assign in_port = (address[1:0] == 2'b00) && (address[15:2] >= port_base)
    && (reg_index <= `T1RX_IDX_ODD_SI);

  // ----------------------------------------------------------------
  // bus handshake: one wait cycle, then ack
  // ----------------------------------------------------------------
  t1rx_stat_pkg::t1rx_bus_state_type bus_state_ff;
  t1rx_stat_pkg::t1rx_bus_state_type nxt_bus_state;
  logic bus_req; // read or write pending
  logic bus_take; // edge where the request completes

  assign bus_req = read | write;
  assign bus_take = bus_req && (bus_state_ff == t1rx_stat_pkg::T1RX_BUS_ACK);
  assign waitrequest = bus_req && (bus_state_ff != t1rx_stat_pkg::T1RX_BUS_ACK);

  // ack lasts one cycle per request
  always_comb begin
    case (bus_state_ff)
      t1rx_stat_pkg::T1RX_BUS_IDLE: begin
        nxt_bus_state = bus_req ? t1rx_stat_pkg::T1RX_BUS_ACK
          : t1rx_stat_pkg::T1RX_BUS_IDLE;
      end
      t1rx_stat_pkg::T1RX_BUS_ACK: begin
        nxt_bus_state = t1rx_stat_pkg::T1RX_BUS_IDLE;
      end
      default: begin
        nxt_bus_state = t1rx_stat_pkg::T1RX_BUS_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bus_state_ff <= t1rx_stat_pkg::T1RX_BUS_IDLE;
    end else begin
      bus_state_ff <= nxt_bus_state;
    end
  end

  // ----------------------------------------------------------------
  // software-writable control (own offsets)
  // ----------------------------------------------------------------
  logic [7:0] ctrl_one_ff; // receive_control_one
  logic [4:0] mon_sel_ff; // monitor_channel_select
  logic wr_low; // low byte lane written this edge

  assign wr_low = bus_take && write && in_port && byteenable[0];
  assign crc4_enable = ctrl_one_ff[`T1RX_CRC4_EN_BIT];

  // status offsets ignore writes
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_one_ff <= `T1RX_RST_BYTE;
      mon_sel_ff <= 5'h00;
    end else if (wr_low && reg_index == `T1RX_IDX_CTRL_ONE) begin
      ctrl_one_ff <= writedata[7:0];
    end else if (wr_low && reg_index == `T1RX_IDX_MON_SEL) begin
      mon_sel_ff <= writedata[4:0];
    end
  end

  // ----------------------------------------------------------------
  // far-end error counters
  // ----------------------------------------------------------------
  logic [15:0] fea_count_ff; // far_end_a_count
  logic [15:0] feb_count_ff; // far_end_b_count

  // [R01] [R02] saturating 16-bit counts
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fea_count_ff <= `T1RX_RST_WORD;
      feb_count_ff <= `T1RX_RST_WORD;
    end else begin
      if (far_end_a_event && fea_count_ff != `T1RX_FEC_MAX) begin
        fea_count_ff <= fea_count_ff + 16'h0001;
      end
      if (far_end_b_event && feb_count_ff != `T1RX_FEC_MAX) begin
        feb_count_ff <= feb_count_ff + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // timeslot monitor
  // ----------------------------------------------------------------
  logic [6:0] mon_shift_ff; // bits so far, first highest
  logic [7:0] mon_byte_ff; // timeslot_monitor_byte

  // [R03] first bit in bit7; loads on the eighth
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mon_shift_ff <= 7'h00;
      mon_byte_ff <= `T1RX_RST_BYTE;
    end else if (rx_bit_valid && rx_timeslot == mon_sel_ff) begin
      mon_shift_ff <= {mon_shift_ff[5:0], rx_bit};
      if (rx_bit_pos == 3'h7) begin
        mon_byte_ff <= {mon_shift_ff, rx_bit};
      end
    end
  end

  // ----------------------------------------------------------------
  // T1 data link, Fs bits and bit-oriented code
  // ----------------------------------------------------------------
  logic [7:0] link_shift_ff; // data_link_bits, earliest shifts to lsb
  logic [2:0] link_count_ff; // bits in the current byte
  logic [5:0] fs_shift_ff; // Fs bits of the current multiframe
  logic [7:0] link_byte_ff; // data_link_byte
  logic [5:0] boc_ff; // bit_oriented_code

  // [R04] [R05] ESF: every eighth bit; D4: Fs at multiframe
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      link_shift_ff <= `T1RX_RST_BYTE;
      link_count_ff <= 3'h0;
      fs_shift_ff <= 6'h00;
      link_byte_ff <= `T1RX_RST_BYTE;
    end else if (!line_mode_e1 && d4_framing) begin
      if (fs_bit_valid) begin
        fs_shift_ff <= {fs_bit, fs_shift_ff[5:1]};
      end
      if (multiframe_start) begin
        link_byte_ff <= {2'b00, fs_shift_ff};
      end
    end else if (!line_mode_e1 && data_link_valid) begin
      link_shift_ff <= {data_link_bits, link_shift_ff[7:1]};
      link_count_ff <= link_count_ff + 3'h1;
      if (link_count_ff == 3'h7) begin
        link_byte_ff <= {data_link_bits, link_shift_ff[7:1]};
      end
    end
  end

  // [R13] only validated codes reach here; the last one is held
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      boc_ff <= 6'h00;
    end else if (!line_mode_e1 && boc_valid) begin
      boc_ff <= boc_bits;
    end
  end

  // ----------------------------------------------------------------
  // SLC-96 link and E1 timeslot-zero captures
  // ----------------------------------------------------------------
  logic [7:0] cap_one_ff; // C8..C1, or align frame byte
  logic [7:0] cap_two_ff; // M2 M1 - - - C11..C9, or non-align byte
  logic [7:0] cap_three_ff; // - S4..S1 A2 A1 M3, or even Si bits
  logic [7:0] odd_si_ff; // odd_frame_intl_bits

  // [R14] [R16] [R17] shared storage by line mode
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cap_one_ff <= `T1RX_RST_BYTE;
      cap_two_ff <= `T1RX_RST_BYTE;
    end else if (!line_mode_e1 && slc_valid) begin
      cap_one_ff <= slc_c_bits[7:0];
      cap_two_ff <= {slc_m_bits[1:0], 3'b010, slc_c_bits[10:8]};
    end else if (line_mode_e1 && ts0_valid && !ts0_frame[0]) begin
      cap_one_ff <= ts0_byte;
    end else if (line_mode_e1 && ts0_valid && ts0_frame[0]) begin
      cap_two_ff <= ts0_byte;
    end
  end

  // [R18] [R19] frames 2k, 2k+1 land in bit k
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_si
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          cap_three_ff[gi] <= 1'b0;
          odd_si_ff[gi] <= 1'b0;
        end else if (!line_mode_e1 && slc_valid) begin
          cap_three_ff[gi] <= gi == 7 ? 1'b1 : gi >= 3 ? slc_s_bits[gi - 3]
            : gi >= 1 ? slc_a_bits[gi - 1] : slc_m_bits[2];
        end else if (line_mode_e1 && ts0_valid && ts0_frame[3:1] == 3'(gi)) begin
          if (ts0_frame[0]) begin
            odd_si_ff[gi] <= ts0_byte[7];
          end else begin
            cap_three_ff[gi] <= ts0_byte[7];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // CRC-4 sync counter
  // ----------------------------------------------------------------
  logic [5:0] csc_ff; // crc4_sync_counter
  logic [7:0] live_status; // crc4_sync_live_status, not latched

  // [R07] [R08] [R09] [R10] clear wins, then saturating count
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      csc_ff <= 6'h00;
    end else if (crc4_sync_found || !crc4_enable) begin
      csc_ff <= 6'h00;
    end else if (crc4_search_timeout && csc_ff != `T1RX_CSC_MAX) begin
      csc_ff <= csc_ff + 6'h01;
    end
  end

  // [R10] [R12] bit1 of the count is dropped to stretch range
  assign live_status = {csc_ff[5:2], csc_ff[0], crc4_search_active,
    cas_search_active, fas_search_active};

  // ----------------------------------------------------------------
  // read data, registered at the wait cycle
  // ----------------------------------------------------------------
  logic [7:0] rd_byte; // selected register value

  // [R06] [R15] shared offsets answer by line mode
  always_comb begin
    rd_byte = 8'h00;
    if (in_port) begin
      case (reg_index)
        `T1RX_IDX_FEA_HIGH: rd_byte = fea_count_ff[15:8];
        `T1RX_IDX_FEA_LOW: rd_byte = fea_count_ff[7:0];
        `T1RX_IDX_FEB_HIGH: rd_byte = feb_count_ff[15:8];
        `T1RX_IDX_FEB_LOW: rd_byte = feb_count_ff[7:0];
        `T1RX_IDX_CTRL_ONE: rd_byte = ctrl_one_ff;
        `T1RX_IDX_TS_MON: rd_byte = mon_byte_ff;
        `T1RX_IDX_MON_SEL: rd_byte = {3'b000, mon_sel_ff};
        `T1RX_IDX_LINK: rd_byte = line_mode_e1 ? live_status : link_byte_ff;
        `T1RX_IDX_BOC: rd_byte = {2'b00, boc_ff};
        `T1RX_IDX_CAP_ONE: rd_byte = cap_one_ff;
        `T1RX_IDX_CAP_TWO: rd_byte = cap_two_ff;
        `T1RX_IDX_CAP_THREE: rd_byte = cap_three_ff;
        `T1RX_IDX_ODD_SI: rd_byte = line_mode_e1 ? odd_si_ff : 8'h00;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // [R21] unmapped and reserved read as zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && bus_state_ff == t1rx_stat_pkg::T1RX_BUS_IDLE) begin
      readdata <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_FEA_COUNT: assert property (@(posedge mclk) disable iff (!reset_n) // [R01]
    far_end_a_event && fea_count_ff != 16'hffff |=> fea_count_ff == $past(fea_count_ff) + 16'h0001)
    else $error("far-end A count did not step");
  AST_FEB_HOLD: assert property (@(posedge mclk) disable iff (!reset_n) // [R02]
    !far_end_b_event |=> $stable(feb_count_ff))
    else $error("B count moved");
  AST_MON_BYTE: assert property (@(posedge mclk) disable iff (!reset_n) // [R03]
    rx_bit_valid && rx_timeslot == mon_sel_ff && rx_bit_pos == 3'h7
    |=> mon_byte_ff[0] == $past(rx_bit) && mon_byte_ff[7:1] == $past(mon_shift_ff))
    else $error("monitor byte order wrong");
  AST_D4_FS: assert property (@(posedge mclk) disable iff (!reset_n) // [R05]
    !line_mode_e1 && d4_framing && multiframe_start |=> link_byte_ff[7:6] == 2'b00)
    else $error("D4 link byte upper bits not zero");
  AST_CSC_CLEAR: assert property (@(posedge mclk) disable iff (!reset_n) // [R08]
    crc4_sync_found |=> csc_ff == 6'h00)
    else $error("sync counter not cleared on sync");
  AST_CSC_DISABLE: assert property (@(posedge mclk) disable iff (!reset_n) // [R09]
    wr_low && reg_index == 14'h005f && !writedata[3] |=> ##1 csc_ff == 6'h00)
    else $error("sync counter not cleared on disable");
  AST_CSC_SAT: assert property (@(posedge mclk) disable iff (!reset_n) // [R10]
    csc_ff == 6'h3f && !crc4_sync_found && crc4_enable |=> csc_ff == 6'h3f)
    else $error("sync counter wrapped");
  AST_CSC_STEP: assert property (@(posedge mclk) disable iff (!reset_n) // [R07]
    crc4_search_timeout && !crc4_sync_found && crc4_enable && csc_ff < 6'h3f
    |=> csc_ff == $past(csc_ff) + 6'h01)
    else $error("sync counter missed a timeout");
  AST_BOC_HOLD: assert property (@(posedge mclk) disable iff (!reset_n) // [R13]
    !line_mode_e1 && boc_valid |=> boc_ff == $past(boc_bits) ##1 ($past(boc_valid) || $stable(boc_ff)))
    else $error("code capture lost");
  AST_RO_WRITE: assert property (@(posedge mclk) disable iff (!reset_n) // [R21]
    bus_take && write && reg_index == 14'h0063 |=> $stable(boc_ff) || $past(boc_valid))
    else $error("status took a write");
  AST_ACK_ONE: assert property (@(posedge mclk) disable iff (!reset_n) // ack lasts one cycle per request
    bus_req && !waitrequest |=> bus_state_ff == t1rx_stat_pkg::T1RX_BUS_IDLE)
    else $error("ack too long");

endmodule : t1rx_stat_regs
`default_nettype wire

// ==== dv/t1rx_line_model.sv ====
// far-end line model: framer-side pulses and levels for one port
// assumes: the bench calls one task at a time; changes follow a rising mclk
`timescale 1ns/1ps
`default_nettype none

module t1rx_line_model (
  input wire logic mclk,
  output logic line_mode_e1,
  output logic d4_framing,
  output logic far_end_a_event,
  output logic far_end_b_event,
  output logic rx_bit_valid,
  output logic rx_bit,
  output logic [4:0] rx_timeslot,
  output logic [2:0] rx_bit_pos,
  output logic data_link_valid,
  output logic data_link_bits,
  output logic fs_bit_valid,
  output logic fs_bit,
  output logic multiframe_start,
  output logic boc_valid,
  output logic [5:0] boc_bits,
  output logic slc_valid,
  output logic [10:0] slc_c_bits,
  output logic [2:0] slc_m_bits,
  output logic [1:0] slc_a_bits,
  output logic [3:0] slc_s_bits,
  output logic ts0_valid,
  output logic [7:0] ts0_byte,
  output logic [3:0] ts0_frame,
  output logic crc4_search_timeout,
  output logic crc4_sync_found,
  output logic crc4_search_active,
  output logic cas_search_active,
  output logic fas_search_active
);
  // ----------------------------------------------------------------
  // line quiet at time zero
  // ----------------------------------------------------------------
  initial begin
    {line_mode_e1, d4_framing, far_end_a_event, far_end_b_event, rx_bit_valid, rx_bit,
     rx_timeslot, rx_bit_pos, data_link_valid, data_link_bits, fs_bit_valid, fs_bit,
     multiframe_start, boc_valid, boc_bits, slc_valid, slc_c_bits, slc_m_bits, slc_a_bits,
     slc_s_bits, ts0_valid, ts0_byte, ts0_frame, crc4_search_timeout, crc4_sync_found,
     crc4_search_active, cas_search_active, fas_search_active} = '0;
  end

  // pulses last one cycle; idle data inverted
  task automatic idle();
    @(posedge mclk);
    {far_end_a_event, far_end_b_event, rx_bit_valid, data_link_valid, fs_bit_valid,
     multiframe_start, boc_valid, slc_valid, ts0_valid, crc4_search_timeout,
     crc4_sync_found} <= '0;
    {rx_bit, data_link_bits, fs_bit, boc_bits, slc_c_bits, slc_m_bits, slc_a_bits,
     slc_s_bits, ts0_byte} <= ~{rx_bit, data_link_bits, fs_bit, boc_bits, slc_c_bits,
     slc_m_bits, slc_a_bits, slc_s_bits, ts0_byte};
  endtask : idle

  // line mode, framing and live search levels
  task automatic lvl(input logic e1, input logic d4, input logic [2:0] act);
    @(posedge mclk);
    line_mode_e1 <= e1;
    d4_framing <= d4;
    {crc4_search_active, cas_search_active, fas_search_active} <= act;
  endtask : lvl

  task automatic far(input logic a, input logic b);
    @(posedge mclk);
    far_end_a_event <= a;
    far_end_b_event <= b;
    idle();
  endtask : far

  // one timeslot, msb first
  task automatic pay(input logic [4:0] ts, input logic [7:0] v);
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk);
      rx_bit_valid <= 1'b1;
      rx_timeslot <= ts;
      rx_bit_pos <= 3'(k);
      rx_bit <= v[7 - k];
      idle();
    end
  endtask : pay

  // data link bits, least significant first
  task automatic dl(input logic [7:0] v);
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk);
      data_link_valid <= 1'b1;
      data_link_bits <= v[k];
      idle();
    end
  endtask : dl

  // six Fs bits, then the boundary if mf
  task automatic fsb(input logic [5:0] v, input logic mf);
    for (int k = 0; k < 6; k++) begin
      @(posedge mclk);
      fs_bit_valid <= 1'b1;
      fs_bit <= v[k];
      idle();
    end
    @(posedge mclk);
    multiframe_start <= mf;
    idle();
  endtask : fsb

  task automatic boc(input logic [5:0] c);
    @(posedge mclk);
    boc_valid <= 1'b1;
    boc_bits <= c;
    idle();
  endtask : boc

  task automatic slc(input logic [10:0] c, input logic [2:0] m, input logic [1:0] a,
                     input logic [3:0] s);
    @(posedge mclk);
    slc_valid <= 1'b1;
    {slc_c_bits, slc_m_bits, slc_a_bits, slc_s_bits} <= {c, m, a, s};
    idle();
  endtask : slc

  task automatic ts0(input logic [3:0] f, input logic [7:0] b);
    @(posedge mclk);
    ts0_valid <= 1'b1;
    ts0_frame <= f;
    ts0_byte <= b;
    idle();
  endtask : ts0

  // search period ran out, or CRC-4 sync found
  task automatic srch(input logic t, input logic f);
    @(posedge mclk);
    crc4_search_timeout <= t;
    crc4_sync_found <= f;
    idle();
  endtask : srch
endmodule : t1rx_line_model
`default_nettype wire

// ==== dv/t1rx_stat_regs_tb_top.sv ====
// self-checking bench for the receive framer status register group
// assumes: the line model drives every line input; the bench owns the bus
`timescale 1ns/1ps
`default_nettype none
`include "t1rx_stat_map.svh"

module t1rx_stat_regs_tb_top;
  localparam logic [3:0] PIDX = 4'h9; // second bank, so both strides count
  localparam logic [13:0] BASE = 14'(`T1RX_PORT_STRIDE * PIDX + `T1RX_BANK_STRIDE * (PIDX / 8));
  logic mclk, reset_n, read, write;
  logic [15:0] address;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  wire logic [31:0] readdata;
  wire logic waitrequest, crc4_enable, line_mode_e1, d4_framing, rx_bit, rx_bit_valid;
  wire logic far_end_a_event, far_end_b_event, data_link_valid, data_link_bits;
  wire logic fs_bit_valid, fs_bit, multiframe_start, boc_valid, slc_valid, ts0_valid;
  wire logic crc4_search_timeout, crc4_sync_found;
  wire logic crc4_search_active, cas_search_active, fas_search_active;
  wire logic [4:0] rx_timeslot;
  wire logic [2:0] rx_bit_pos, slc_m_bits;
  wire logic [5:0] boc_bits;
  wire logic [10:0] slc_c_bits;
  wire logic [1:0] slc_a_bits;
  wire logic [3:0] slc_s_bits, ts0_frame;
  wire logic [7:0] ts0_byte;
  int err_total = 0;
  int comparisons = 0;

  t1rx_stat_regs #(.PORT_INDEX(PIDX)) dut (
    .mclk, .reset_n, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .line_mode_e1, .d4_framing, .far_end_a_event, .far_end_b_event,
    .rx_bit_valid, .rx_bit, .rx_timeslot, .rx_bit_pos, .data_link_valid, .data_link_bits,
    .fs_bit_valid, .fs_bit, .multiframe_start, .boc_valid, .boc_bits, .slc_valid,
    .slc_c_bits, .slc_m_bits, .slc_a_bits, .slc_s_bits, .ts0_valid, .ts0_byte, .ts0_frame,
    .crc4_search_timeout, .crc4_sync_found, .crc4_search_active, .cas_search_active,
    .fas_search_active, .crc4_enable
  );

  t1rx_line_model line (.*);

  always #4 mclk = ~mclk;

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [13:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd);
    int n;
    @(posedge mclk);
    address <= {idx, 2'b00};
    read <= ~wr;
    write <= wr;
    writedata <= {24'h00_0000, wd};
    for (n = 0; n < 64; n++) begin
      @(negedge mclk);
      if (waitrequest === 1'b0) break;
      @(posedge mclk);
    end
    @(posedge mclk);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n == 64) begin
      err_total++;
      end_sim();
    end
  endtask : bus

  task automatic rchk(input string what, input logic [13:0] idx, input logic [7:0] exp,
                      input logic [7:0] m = 8'hff);
    logic [31:0] rd;
    bus(1'b0, BASE + idx, 8'h00, rd);
    chk(what, {24'h00_0000, exp & m}, rd & {24'hff_ffff, m});
  endtask : rchk

  task automatic wr(input logic [13:0] idx, input logic [7:0] v);
    logic [31:0] rd;
    bus(1'b1, BASE + idx, v, rd);
  endtask : wr

  // live status with crc4 search flag set
  function automatic logic [7:0] seen(input logic [5:0] c);
    return {c[5:2], c[0], 3'b100};
  endfunction : seen

  task automatic s_reset();
    for (logic [13:0] i = 14'h0058; i < 14'h0068; i++) begin
      if (i != `T1RX_IDX_CTRL_ONE && i != `T1RX_IDX_MON_SEL) rchk("reset", i, 8'h00);
    end
    wr(`T1RX_IDX_FEA_LOW, 8'hff);
    rchk("written status", `T1RX_IDX_FEA_LOW, 8'h00);
    rchk("unmapped", 14'h0070, 8'h00);
    chk("crc4 enable", 32'h0000_0000, {31'h0000_0000, crc4_enable});
  endtask : s_reset

  task automatic s_count();
    logic [31:0] rd;
    repeat (3) line.far(1'b1, 1'b1);
    repeat (256) line.far(1'b0, 1'b1);
    rchk("count a high", `T1RX_IDX_FEA_HIGH, 8'h00);
    rchk("count a low", `T1RX_IDX_FEA_LOW, 8'h03);
    rchk("count b high", `T1RX_IDX_FEB_HIGH, 8'h01);
    rchk("count b low", `T1RX_IDX_FEB_LOW, 8'h03);
    bus(1'b0, BASE - `T1RX_PORT_STRIDE + `T1RX_IDX_FEA_LOW, 8'h00, rd);
    chk("other port", 32'h0000_0000, rd);
    wr(`T1RX_IDX_MON_SEL, 8'h05);
    line.pay(5'h04, 8'h3c);
    line.pay(5'h05, 8'ha6);
    line.pay(5'h06, 8'h11);
    rchk("monitor", `T1RX_IDX_TS_MON, 8'ha6);
  endtask : s_count

  task automatic s_t1();
    line.lvl(1'b0, 1'b0, 3'b000);
    line.dl(8'hb4);
    rchk("esf link", `T1RX_IDX_LINK, 8'hb4);
    line.lvl(1'b0, 1'b1, 3'b000);
    line.fsb(6'h2d, 1'b0);
    rchk("d4 early", `T1RX_IDX_LINK, 8'hb4);
    line.fsb(6'h2d, 1'b1);
    rchk("d4 fs bits", `T1RX_IDX_LINK, 8'h2d, 8'h3f);
    line.boc(6'h2b);
    rchk("code", `T1RX_IDX_BOC, 8'h2b);
    line.slc(11'h5a3, 3'b101, 2'b10, 4'b0110);
    rchk("slc one", `T1RX_IDX_CAP_ONE, 8'ha3);
    rchk("slc two", `T1RX_IDX_CAP_TWO, 8'h55);
    rchk("slc three", `T1RX_IDX_CAP_THREE, 8'hb5);
  endtask : s_t1

  task automatic s_e1();
    logic [15:0] si;
    logic [7:0] ev, od;
    si = 16'hc35a;
    line.lvl(1'b1, 1'b0, 3'b000);
    for (int f = 0; f < 16; f++) begin
      if (f % 2 == 0) begin
        line.ts0(4'(f), {si[f], 7'h1b});
        ev[f / 2] = si[f];
      end else begin
        line.ts0(4'(f), {si[f], 3'b101, 4'(f)});
        od[f / 2] = si[f];
      end
    end
    rchk("align byte", `T1RX_IDX_CAP_ONE, {si[14], 7'h1b});
    rchk("nonalign byte", `T1RX_IDX_CAP_TWO, {si[15], 7'h5f});
    rchk("even si", `T1RX_IDX_CAP_THREE, ev);
    rchk("odd si", `T1RX_IDX_ODD_SI, od);
    for (int k = 0; k < 3; k++) begin
      line.lvl(1'b1, 1'b0, 3'(1 << k));
      rchk("search flag", `T1RX_IDX_LINK, 8'(1 << k));
    end
    line.lvl(1'b0, 1'b0, 3'b000);
    rchk("odd si in t1", `T1RX_IDX_ODD_SI, 8'h00);
  endtask : s_e1

  task automatic s_sync();
    line.lvl(1'b1, 1'b0, 3'b100);
    wr(`T1RX_IDX_CTRL_ONE, 8'h08);
    @(posedge mclk);
    chk("crc4 enable", 32'h0000_0001, {31'h0000_0000, crc4_enable});
    repeat (5) line.srch(1'b1, 1'b0);
    rchk("sync count", `T1RX_IDX_LINK, seen(6'h05));
    line.srch(1'b0, 1'b1);
    rchk("sync found", `T1RX_IDX_LINK, seen(6'h00));
    repeat (70) line.srch(1'b1, 1'b0);
    rchk("sync saturated", `T1RX_IDX_LINK, seen(6'h3f));
    // controller gives up: CRC-4 off
    wr(`T1RX_IDX_CTRL_ONE, 8'h00);
    line.srch(1'b1, 1'b0);
    rchk("sync disabled", `T1RX_IDX_LINK, seen(6'h00));
  endtask : s_sync

  initial begin
    {mclk, reset_n, read, write} = 4'h0;
    address = 16'h0000;
    writedata = 32'h0000_0000;
    byteenable = 4'hf;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    s_reset();
    s_count();
    s_t1();
    s_e1();
    s_sync();
    end_sim();
  end
endmodule : t1rx_stat_regs_tb_top
`default_nettype wire
